// ### hdl/fpic_top.v
// Front panel indicator, buzzer and key control with a Wishbone register slave.
`timescale 1ns/10ps
`include "fpic_consts.vh"

module fpic_top #(
	parameter MS_CYC = `FPIC_MS_CYC
) (
	input  wire                clk_i,
	input  wire                rst_i,
	input  wire                wb_cyc_i,
	input  wire                wb_stb_i,
	input  wire                wb_we_i,
	input  wire [7:0]          wb_adr_i,
	input  wire [3:0]          wb_sel_i,
	input  wire [31:0]         wb_dat_i,
	output reg  [31:0]         wb_dat_o,
	output reg                 wb_ack_o,
	input  wire [`FPIC_K_W-1:0] key_i,
	input  wire                keyswitch_on_i,
	output reg  [`FPIC_L_W-1:0] led_o,
	output reg                 buzzer_o,
	output reg                 silence_o,
	output reg                 force_fire_o,
	output reg                 reset_o
);

	function [31:0] fpic_merge;
		input [31:0] old_v;
		input [31:0] new_v;
		input [3:0]  sel;
		integer      i;
		begin
			for (i = 0; i < 32; i = i + 1)
				fpic_merge[i] = sel[i/8] ? new_v[i] : old_v[i];
		end
	endfunction

	// ********************************************************
	// Declarations
	// ********************************************************
	reg  [`FPIC_C_W-1:0]   cond_r;
	reg  [`FPIC_F_W-1:0]   fault_r;
	reg  [7:0]             zones_r;
	reg  [`FPIC_K_W-1:0]   keyev_r;
	reg  [`FPIC_K_W:0]     sync1_r;
	reg  [`FPIC_K_W:0]     sync2_r;
	reg  [`FPIC_K_W-1:0]   kprev_r;
	reg  [31:0]            pre_r;
	reg                    tick_r;
	reg  [15:0]            flash_ms_r;
	reg                    flash_r;
	reg  [15:0]            cad_ms_r;
	reg  [15:0]            win_ms_r;
	reg  [15:0]            hold_ms_r;
	reg  [15:0]            beep_ms_r;
	reg                    beep_act_r;
	reg                    beep_dbl_r;
	reg                    fire_lat_r;
	reg                    route_lat_r;
	reg                    fon_lat_r;
	reg                    sys_lat_r;
	reg                    silenced_r;
	reg                    mute_r;
	reg                    anc_dis_r;
	reg                    alarm_prev_r;
	reg  [`FPIC_F_SRC_W-1:0] src_prev_r;
	wire                   wb_req;
	wire                   wb_wr;
	wire [3:0]             wb_idx;
	wire [`FPIC_K_W-1:0]   key_s;
	wire                   level2;
	wire [`FPIC_K_W-1:0]   press;
	wire [`FPIC_K_W-1:0]   accept;
	wire                   held;
	wire                   rst_key;
	wire                   flt_any;
	wire                   new_alarm;
	wire                   dly_avail;
	wire                   beep_on;
	wire                   cad_on;
	wire [31:0]            status;
	reg  [`FPIC_L_W-1:0]   led_nxt;

	// ********************************************************
	// Key synchronisers and acceptance
	// ********************************************************
	always @(posedge clk_i) begin
		if (rst_i) begin
			sync1_r <= {(`FPIC_K_W+1){1'b0}};
			sync2_r <= {(`FPIC_K_W+1){1'b0}};
			kprev_r <= {`FPIC_K_W{1'b0}};
		end else begin
			sync1_r <= {keyswitch_on_i, key_i};
			sync2_r <= sync1_r;
			kprev_r <= key_s;
		end
	end

	assign key_s   = sync2_r[`FPIC_K_W-1:0];
	assign level2  = sync2_r[`FPIC_K_W];
	assign press   = key_s & ~kprev_r;
	// Level 1 keeps only browsing and buzzer mute.
	assign accept  = press & (level2 ? {`FPIC_K_W{1'b1}} : `FPIC_K_LVL1);
	assign held    = |key_s;
	assign rst_key = accept[`FPIC_K_RESET];

	// ********************************************************
	// Millisecond tick and flash generator
	// ********************************************************
	always @(posedge clk_i) begin
		if (rst_i) begin
			pre_r      <= 32'h0000_0000;
			tick_r     <= 1'b0;
			flash_ms_r <= 16'h0000;
			flash_r    <= 1'b0;
		end else begin
			tick_r <= (pre_r == MS_CYC - 1);
			pre_r  <= (pre_r == MS_CYC - 1) ? 32'h0000_0000 : pre_r + 32'h0000_0001;
			if (tick_r) begin
				if (flash_ms_r == `FPIC_FLASH_MS - 16'd1) begin
					flash_ms_r <= 16'h0000;
					flash_r    <= ~flash_r;
				end else begin
					flash_ms_r <= flash_ms_r + 16'd1;
				end
			end
		end
	end

	// ********************************************************
	// Wishbone slave
	// ********************************************************
	// Ack is registered, so each access costs one wait state and stb must
	// stay up until ack is seen; a write is stored on the taking edge.
	assign wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	assign wb_wr  = wb_req & wb_we_i;
	assign wb_idx = wb_adr_i[5:2];
	assign status = {3'h0, level2, (win_ms_r != 16'h0000), anc_dis_r, silenced_r,
		buzzer_o, 7'h00, led_o};

	always @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
		end else begin
			wb_ack_o <= wb_req;
			wb_dat_o <= 32'h0000_0000;
			if (wb_req & ~wb_we_i & (wb_adr_i[7:6] == 2'b00)) begin
				case (wb_idx)
				`FPIC_OFS_COND:   wb_dat_o <= {{(32-`FPIC_C_W){1'b0}}, cond_r};
				`FPIC_OFS_FAULT:  wb_dat_o <= {{(32-`FPIC_F_W){1'b0}}, fault_r};
				`FPIC_OFS_ZONES:  wb_dat_o <= {24'h00_0000, zones_r};
				`FPIC_OFS_STATUS: wb_dat_o <= status;
				`FPIC_OFS_KEYEV:  wb_dat_o <= {{(32-`FPIC_K_W){1'b0}}, keyev_r};
				default:          wb_dat_o <= 32'h0000_0000;
				endcase
			end
		end
	end

	// ********************************************************
	// Software registers
	// ********************************************************
	wire wr_cond  = wb_wr & (wb_adr_i[7:6] == 2'b00) & (wb_idx == `FPIC_OFS_COND);
	wire wr_fault = wb_wr & (wb_adr_i[7:6] == 2'b00) & (wb_idx == `FPIC_OFS_FAULT);
	wire wr_zones = wb_wr & (wb_adr_i[7:6] == 2'b00) & (wb_idx == `FPIC_OFS_ZONES);
	wire wr_keyev = wb_wr & (wb_adr_i[7:6] == 2'b00) & (wb_idx == `FPIC_OFS_KEYEV);
	wire [31:0] m_cond  = fpic_merge({{(32-`FPIC_C_W){1'b0}}, cond_r}, wb_dat_i, wb_sel_i);
	wire [31:0] m_fault = fpic_merge({{(32-`FPIC_F_W){1'b0}}, fault_r}, wb_dat_i, wb_sel_i);
	wire [31:0] m_zones = fpic_merge({24'h00_0000, zones_r}, wb_dat_i, wb_sel_i);
	wire [31:0] m_kclr  = fpic_merge(32'h0000_0000, wb_dat_i, wb_sel_i);

	always @(posedge clk_i) begin
		if (rst_i) begin
			cond_r  <= `FPIC_RST_COND;
			fault_r <= `FPIC_RST_FAULT;
			zones_r <= `FPIC_RST_ZONES;
			keyev_r <= {`FPIC_K_W{1'b0}};
		end else begin
			if (wr_cond)
				cond_r <= m_cond[`FPIC_C_W-1:0];
			if (wr_zones)
				zones_r <= m_zones[7:0];
			// Reset drops fault sources; a write in the same cycle reasserts them.
			if (wr_fault)
				fault_r <= m_fault[`FPIC_F_W-1:0];
			else if (rst_key)
				fault_r[`FPIC_F_SRC_W-1:0] <= {`FPIC_F_SRC_W{1'b0}};
			// Write one to clear; a new accepted key in the same cycle survives.
			keyev_r <= (keyev_r & ~(wr_keyev ? m_kclr[`FPIC_K_W-1:0] :
				{`FPIC_K_W{1'b0}})) | accept;
		end
	end

	// ********************************************************
	// Latched conditions and silence control
	// ********************************************************
	// The reassert window is only reported in status; software must rewrite
	// any fault source that still stands before the window closes.
	assign flt_any   = |fault_r[`FPIC_F_SRC_W-1:0];
	assign new_alarm = (fire_lat_r & ~alarm_prev_r) |
		(|(fault_r[`FPIC_F_SRC_W-1:0] & ~src_prev_r));

	always @(posedge clk_i) begin
		if (rst_i) begin
			fire_lat_r   <= 1'b0;
			route_lat_r  <= 1'b0;
			fon_lat_r    <= 1'b0;
			sys_lat_r    <= 1'b0;
			silenced_r   <= 1'b0;
			mute_r       <= 1'b0;
			anc_dis_r    <= 1'b0;
			alarm_prev_r <= 1'b0;
			src_prev_r   <= {`FPIC_F_SRC_W{1'b0}};
			win_ms_r     <= 16'h0000;
			reset_o      <= 1'b0;
			force_fire_o <= 1'b0;
			silence_o    <= 1'b0;
		end else begin
			alarm_prev_r <= fire_lat_r;
			src_prev_r   <= fault_r[`FPIC_F_SRC_W-1:0];
			reset_o      <= rst_key;
			// Set terms are listed last so a live condition outlasts a reset.
			if (rst_key) begin
				fire_lat_r  <= 1'b0;
				route_lat_r <= 1'b0;
				fon_lat_r   <= 1'b0;
				sys_lat_r   <= 1'b0;
				silenced_r  <= 1'b0;
			end
			if (cond_r[`FPIC_C_FIRE] | cond_r[`FPIC_C_EVAC])
				fire_lat_r <= 1'b1;
			if (cond_r[`FPIC_C_ROUTE])
				route_lat_r <= 1'b1;
			if (cond_r[`FPIC_C_FOUT])
				fon_lat_r <= 1'b1;
			if (cond_r[`FPIC_C_SYSFAIL])
				sys_lat_r <= 1'b1;
			// Toggle only when silenceable devices exist; silencing also needs a standing alarm.
			if (accept[`FPIC_K_SILRES] & cond_r[`FPIC_C_SILABLE] & ~rst_key) begin
				if (silenced_r)
					silenced_r <= 1'b0;
				else if (fire_lat_r)
					silenced_r <= 1'b1;
			end
			silence_o <= silenced_r;
			// A fresh alarm or fault re-arms a muted buzzer.
			if (new_alarm)
				mute_r <= 1'b0;
			else if (accept[`FPIC_K_SILBZ])
				mute_r <= 1'b1;
			if (accept[`FPIC_K_ANCDIS])
				anc_dis_r <= ~anc_dis_r;
			if (rst_key)
				win_ms_r <= `FPIC_REASSERT_MS;
			else if (tick_r && win_ms_r != 16'h0000)
				win_ms_r <= win_ms_r - 16'd1;
			force_fire_o <= cond_r[`FPIC_C_DLY_RUN] &
				(cond_r[`FPIC_C_OVERRIDE] | cond_r[`FPIC_C_EVAC]);
		end
	end

	// ********************************************************
	// Buzzer cadence and key beeps
	// ********************************************************
	assign cad_on  = cad_ms_r < `FPIC_BZ_ON_MS;
	assign beep_on = beep_act_r & ((beep_ms_r < `FPIC_BEEP_MS) |
		(beep_dbl_r & (beep_ms_r >= `FPIC_BEEP2_ON_MS)));

	always @(posedge clk_i) begin
		if (rst_i) begin
			cad_ms_r   <= 16'h0000;
			hold_ms_r  <= 16'h0000;
			beep_ms_r  <= 16'h0000;
			beep_act_r <= 1'b0;
			beep_dbl_r <= 1'b0;
			buzzer_o   <= 1'b0;
		end else begin
			if (~flt_any | fire_lat_r)
				cad_ms_r <= 16'h0000;
			else if (tick_r)
				cad_ms_r <= (cad_ms_r == `FPIC_BZ_PER_MS - 16'd1) ? 16'h0000 :
					cad_ms_r + 16'd1;
			if (~held)
				hold_ms_r <= 16'h0000;
			else if (tick_r && hold_ms_r != `FPIC_LONG_MS)
				hold_ms_r <= hold_ms_r + 16'd1;
			if (held && tick_r && hold_ms_r == `FPIC_LONG_MS - 16'd1) begin
				beep_act_r <= 1'b1;
				beep_dbl_r <= 1'b1;
				beep_ms_r  <= 16'h0000;
			end else if (~held && (|kprev_r) && hold_ms_r != `FPIC_LONG_MS) begin
				beep_act_r <= 1'b1;
				beep_dbl_r <= 1'b0;
				beep_ms_r  <= 16'h0000;
			end else if (tick_r && beep_act_r) begin
				if (beep_ms_r == (beep_dbl_r ? `FPIC_BEEP2_END_MS : `FPIC_BEEP_MS) - 16'd1)
					beep_act_r <= 1'b0;
				beep_ms_r <= beep_ms_r + 16'd1;
			end
			buzzer_o <= beep_on | (~mute_r & (fire_lat_r | (flt_any & cad_on)));
		end
	end

	// ********************************************************
	// Indicators
	// ********************************************************
	assign dly_avail = cond_r[`FPIC_C_DLY_MODE] & cond_r[`FPIC_C_DLY_CFG] &
		cond_r[`FPIC_C_DLY_DN];

	always @* begin
		led_nxt = {`FPIC_L_W{1'b0}};
		led_nxt[`FPIC_L_FIRE]    = fire_lat_r;
		led_nxt[`FPIC_L_ROUTE]   = route_lat_r;
		led_nxt[`FPIC_L_POWER]   = cond_r[`FPIC_C_MAINS] | flash_r;
		led_nxt[`FPIC_L_PWRFLT]  = ~cond_r[`FPIC_C_MAINS] | cond_r[`FPIC_C_CHG_HI] |
			cond_r[`FPIC_C_BAT_LO] | cond_r[`FPIC_C_BAT_MISS];
		led_nxt[`FPIC_L_SYSFLT]  = sys_lat_r;
		led_nxt[`FPIC_L_EARTH]   = cond_r[`FPIC_C_EARTH];
		// Disabled wins over faulty on every output status LED.
		led_nxt[`FPIC_L_ALMDEV]  = fault_r[`FPIC_F_ALM_DIS] |
			(fault_r[`FPIC_F_ALM_FLT] & flash_r);
		led_nxt[`FPIC_L_FOUT_ST] = fault_r[`FPIC_F_FO_DIS] |
			(fault_r[`FPIC_F_FO_FLT] & flash_r);
		led_nxt[`FPIC_L_FLO_ST]  = fault_r[`FPIC_F_FLO_DIS] |
			(fault_r[`FPIC_F_FLO_FLT] & flash_r);
		led_nxt[`FPIC_L_ANC_ST]  = fault_r[`FPIC_F_ANC_DIS] | anc_dis_r |
			(fault_r[`FPIC_F_ANC_FLT] & flash_r);
		led_nxt[`FPIC_L_TEST]    = cond_r[`FPIC_C_WALK];
		led_nxt[`FPIC_L_FOUT_ON] = fon_lat_r;
		led_nxt[`FPIC_L_PREALM]  = cond_r[`FPIC_C_PREALM];
		led_nxt[`FPIC_L_DELAY]   = dly_avail & (~cond_r[`FPIC_C_DLY_RUN] |
			cond_r[`FPIC_C_OVERRIDE] | cond_r[`FPIC_C_EVAC] | flash_r);
		led_nxt[`FPIC_L_SEVERAL] = zones_r > 8'h01;
		led_nxt[`FPIC_L_SILENCED] = silenced_r;
		led_nxt[`FPIC_L_GENFLT]  = flt_any;
	end

	always @(posedge clk_i) begin
		if (rst_i)
			led_o <= {`FPIC_L_W{1'b0}};
		else
			led_o <= led_nxt;
	end

endmodule // fpic_top

// ### hdl/fpic_consts.vh
// Constants of the front panel indicator controller: offsets, fields, timing.
`ifndef FPIC_CONSTS_VH
`define FPIC_CONSTS_VH
// ********************************************************
// Timing
// ********************************************************
`define FPIC_CLK_HZ       50000000
`define FPIC_MS_CYC       (`FPIC_CLK_HZ / 1000)
`define FPIC_BZ_ON_MS     16'd1000
`define FPIC_BZ_PER_MS    16'd5500
`define FPIC_FLASH_MS     16'd500
`define FPIC_REASSERT_MS  16'd20000
`define FPIC_LONG_MS      16'd1000
`define FPIC_BEEP_MS      16'd100
`define FPIC_BEEP2_ON_MS  16'd200
`define FPIC_BEEP2_END_MS 16'd300
// ********************************************************
// Register word offsets (wb_adr_i[5:2])
// ********************************************************
`define FPIC_OFS_COND     4'h0
`define FPIC_OFS_FAULT    4'h1
`define FPIC_OFS_ZONES    4'h2
`define FPIC_OFS_STATUS   4'h3
`define FPIC_OFS_KEYEV    4'h4
// ********************************************************
// Reset values
// ********************************************************
`define FPIC_RST_COND     18'h0_0010
`define FPIC_RST_FAULT    16'h0000
`define FPIC_RST_ZONES    8'h00
// ********************************************************
// Condition register fields
// ********************************************************
`define FPIC_C_FIRE       0
`define FPIC_C_EVAC       1
`define FPIC_C_ROUTE      2
`define FPIC_C_FOUT       3
`define FPIC_C_MAINS      4
`define FPIC_C_CHG_HI     5
`define FPIC_C_BAT_LO     6
`define FPIC_C_BAT_MISS   7
`define FPIC_C_SYSFAIL    8
`define FPIC_C_EARTH      9
`define FPIC_C_WALK       10
`define FPIC_C_PREALM     11
`define FPIC_C_DLY_MODE   12
`define FPIC_C_DLY_CFG    13
`define FPIC_C_DLY_DN     14
`define FPIC_C_DLY_RUN    15
`define FPIC_C_OVERRIDE   16
`define FPIC_C_SILABLE    17
`define FPIC_C_W          18
// ********************************************************
// Fault register fields
// ********************************************************
`define FPIC_F_SRC_W      7
`define FPIC_F_ALM_DIS    8
`define FPIC_F_ALM_FLT    9
`define FPIC_F_FO_DIS     10
`define FPIC_F_FO_FLT     11
`define FPIC_F_FLO_DIS    12
`define FPIC_F_FLO_FLT    13
`define FPIC_F_ANC_DIS    14
`define FPIC_F_ANC_FLT    15
`define FPIC_F_W          16
// ********************************************************
// LED vector positions and keys
// ********************************************************
`define FPIC_L_FIRE       0
`define FPIC_L_ROUTE      1
`define FPIC_L_POWER      2
`define FPIC_L_PWRFLT     3
`define FPIC_L_SYSFLT     4
`define FPIC_L_EARTH      5
`define FPIC_L_ALMDEV     6
`define FPIC_L_FOUT_ST    7
`define FPIC_L_FLO_ST     8
`define FPIC_L_ANC_ST     9
`define FPIC_L_TEST       10
`define FPIC_L_FOUT_ON    11
`define FPIC_L_PREALM     12
`define FPIC_L_DELAY      13
`define FPIC_L_SEVERAL    14
`define FPIC_L_SILENCED   15
`define FPIC_L_GENFLT     16
`define FPIC_L_W          17
`define FPIC_K_PREV       0
`define FPIC_K_NEXT       1
`define FPIC_K_SILBZ      2
`define FPIC_K_SILRES     3
`define FPIC_K_RESET      4
`define FPIC_K_MENU       5
`define FPIC_K_PTDIS      6
`define FPIC_K_ANCDIS     7
`define FPIC_K_CANCEL     8
`define FPIC_K_W          9
`define FPIC_K_LVL1       9'h007
`endif

// ### tb/fpic_props.sv
// Port-level assertions for the front panel indicator controller.
`timescale 1ns/10ps
`include "fpic_consts.vh"
module fpic_props (
	input wire                 clk_i,
	input wire                 rst_i,
	input wire                 wb_cyc_i,
	input wire                 wb_stb_i,
	input wire                 wb_we_i,
	input wire [7:0]           wb_adr_i,
	input wire [3:0]           wb_sel_i,
	input wire [31:0]          wb_dat_i,
	input wire                 wb_ack_o,
	input wire [`FPIC_L_W-1:0] led_o,
	input wire                 reset_o
);
	default clocking dc @(posedge clk_i); endclocking
	default disable iff (rst_i);
	// Shadow of written registers; LEDs are judged only once a write has had time to settle.
	reg  [31:0] cond_r;
	reg  [7:0]  zone_r;
	reg  [1:0]  stab_r;
	wire        wr_w = wb_ack_o & wb_stb_i & wb_we_i;
	wire        st_w = (stab_r == 2'h3) & !wb_ack_o;
	wire [31:0] msk_w = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
	always @(posedge clk_i) begin
		if (rst_i) begin
			cond_r <= {14'h0000, `FPIC_RST_COND};
			zone_r <= 8'h00;
			stab_r <= 2'h0;
		end else begin
			stab_r <= wr_w ? 2'h0 : stab_r + {1'b0, stab_r != 2'h3};
			if (wr_w && wb_adr_i == 8'h00)
				cond_r <= (cond_r & ~msk_w) | (wb_dat_i & msk_w);
			if (wr_w && wb_adr_i == 8'h08 && wb_sel_i[0])
				zone_r <= wb_dat_i[7:0];
		end
	end
	a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("Request not answered in one cycle.");
	a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("Acknowledge longer than one cycle.");
	a_reset_pulse: assert property ($rose(reset_o) |=> $fell(reset_o))
		else $error("Reset output not a single pulse.");
	a_fire_shown: assert property (st_w && (cond_r[0] || cond_r[1]) |-> led_o[0])
		else $error("Fire LED dark with fire or evacuate.");
	a_power_steady: assert property (st_w && cond_r[4] |-> led_o[2])
		else $error("Power LED dark with mains present.");
	a_power_fault: assert property (st_w |-> led_o[3] == (!cond_r[4] || |cond_r[7:5]))
		else $error("Power fault LED wrong.");
	a_earth_fault: assert property (st_w |-> led_o[5] == cond_r[9])
		else $error("Earth fault LED wrong.");
	a_walk_test: assert property (st_w |-> led_o[10] == cond_r[10])
		else $error("Test LED wrong.");
	a_pre_alarm: assert property (st_w |-> led_o[12] == cond_r[11])
		else $error("Pre-alarm LED wrong.");
	a_several_zones: assert property (st_w |-> led_o[14] == (zone_r > 8'h01))
		else $error("Several alarms LED wrong.");
endmodule // fpic_props

// ### tb/fpic_operator.sv
// Operator model: front panel keys and the keyswitch.
`timescale 1ns/10ps
module fpic_operator (
	input  wire       clk_i,
	output reg  [8:0] key_o,
	output reg        keyswitch_on_o
);
	initial begin
		key_o = 9'h000;
		keyswitch_on_o = 1'b0;
	end
	// Changes land just after an edge; the design resynchronises them anyway.
	task set_key(input integer k, input v);
		begin
			@(posedge clk_i);
			key_o[k] <= v;
		end
	endtask
	task set_switch(input v);
		begin
			@(posedge clk_i);
			keyswitch_on_o <= v;
		end
	endtask
endmodule // fpic_operator

// ### tb/front_panel_indicator_control_test.sv
// Self-checking bench for the front panel indicator controller.
`timescale 1ns/10ps
`include "fpic_consts.vh"
module front_panel_indicator_control_test;
	localparam MS = 2;
	reg         clk_i;
	reg         rst_i;
	reg         wb_cyc_i;
	reg         wb_stb_i;
	reg         wb_we_i;
	reg  [7:0]  wb_adr_i;
	reg  [3:0]  wb_sel_i;
	reg  [31:0] wb_dat_i;
	wire [31:0] wb_dat_o;
	wire        wb_ack_o;
	wire [8:0]  key_w;
	wire        ks_w;
	wire [16:0] led_o;
	wire        buzzer_o;
	wire        silence_o;
	wire        force_fire_o;
	wire        reset_o;
	wire [18:0] obs_w = {silence_o, buzzer_o, led_o};
	integer     failures;
	integer     tests_run;
	integer     seed;
	integer     pulses;
	integer     i;
	reg  [31:0] rd;
	reg  [31:0] c;
	wire [4:0]  lv_w = {led_o[14], led_o[12], led_o[10], led_o[5], led_o[3]};
	wire [6:0]  lat_w = {pulses[3:0], led_o[11], led_o[4], led_o[1]};
	fpic_top #(.MS_CYC(MS)) fpic_top_i (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
		.wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
		.wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .key_i(key_w),
		.keyswitch_on_i(ks_w), .led_o(led_o), .buzzer_o(buzzer_o), .silence_o(silence_o),
		.force_fire_o(force_fire_o), .reset_o(reset_o));
	fpic_operator fpic_operator_i (.clk_i(clk_i), .key_o(key_w), .keyswitch_on_o(ks_w));
	initial begin
		clk_i = 1'b0;
		forever #10 clk_i = ~clk_i;
	end
	always @(posedge clk_i)
		if (reset_o === 1'b1)
			pulses <= pulses + 1;
	task check(input [31:0] s, input [31:0] e);
		begin
			tests_run = tests_run + 1;
			if (s !== e) begin
				failures = failures + 1;
				$display("CHECK FAILED at %0t seen %h expected %h", $time, s, e);
			end
		end
	endtask
	task cyc(input integer k);
		repeat (k) @(posedge clk_i);
	endtask
	task bus(input w, input [7:0] a, input [31:0] d, input [3:0] s);
		integer n;
		begin
			wb_cyc_i <= 1'b1;
			wb_stb_i <= 1'b1;
			wb_we_i <= w;
			wb_adr_i <= a;
			wb_dat_i <= d;
			wb_sel_i <= s;
			n = 0;
			@(posedge clk_i);
			while (wb_ack_o !== 1'b1 && n < 20) begin
				@(posedge clk_i);
				n = n + 1;
			end
			if (n == 20)
				check(n, 0);
			rd = wb_dat_o;
			wb_cyc_i <= 1'b0;
			wb_stb_i <= 1'b0;
			@(posedge clk_i);
		end
	endtask
	task press(input integer k);
		begin
			fpic_operator_i.set_key(k, 1'b1);
			cyc(10);
			fpic_operator_i.set_key(k, 1'b0);
			cyc(400);
		end
	endtask
	// Samples across 1200 ms, just over one flash period: 0 off, 1 flashing, 2 steady.
	task mode(input integer b, input [1:0] e);
		integer k;
		integer n;
		begin
			n = 0;
			for (k = 0; k < 12; k = k + 1) begin
				cyc(200);
				n = n + obs_w[b];
			end
			check((n == 0) ? 0 : (n == 12) ? 2 : 1, e);
		end
	endtask
	function [4:0] lvl(input [31:0] v, input [1:0] z);
		lvl = {z > 2'h1, v[11], v[10], v[9], !v[4] | |v[7:5]};
	endfunction
	function [31:0] dly(input integer k);
		dly = (k == 0) ? 32'h7010 : (k == 1) ? 32'hf010 : (k == 2) ? 32'h1f010 :
			(k == 3) ? 32'h6010 : (k == 4) ? 32'h5010 : 32'h3010;
	endfunction
	task results;
		begin
			if (failures == 0 && tests_run > 0)
				$display("SIMULATION PASSED");
			else
				$display("SIMULATION FAILED");
			$finish;
		end
	endtask
	initial begin
		#(20 * 90000);
		failures = failures + 1;
		results;
	end
	initial begin
		failures = 0;
		tests_run = 0;
		seed = 47;
		pulses = 0;
		rst_i = 1'b1;
		wb_cyc_i = 1'b0;
		wb_stb_i = 1'b0;
		wb_we_i = 1'b0;
		wb_adr_i = 8'h00;
		wb_sel_i = 4'h0;
		wb_dat_i = 32'h0;
		repeat (8) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		for (i = 0; i < 3; i = i + 1) begin
			bus(1'b0, 4 * i, 32'h0, 4'hf);
			check(rd, (i == 0) ? `FPIC_RST_COND : 32'h0);
		end
		check(led_o[2], 1'b1);
		bus(1'b0, 8'h0c, 32'h0, 4'hf);
		c = rd;
		bus(1'b1, 8'h0c, 32'hffffffff, 4'hf);
		bus(1'b0, 8'h0c, 32'h0, 4'hf);
		check(rd, c);
		bus(1'b1, 8'h40, 32'hffffffff, 4'hf);
		bus(1'b0, 8'h40, 32'h0, 4'hf);
		check(rd, 32'h0);
		for (i = 0; i < 8; i = i + 1) begin
			rd = $random(seed);
			c = (i == 0) ? 32'h0 : rd & 32'h0ef0;
			rd[13:12] = (i == 1) ? 2'h1 : rd[13:12];
			bus(1'b1, 8'h00, c, 4'hf);
			bus(1'b1, 8'h08, {30'h0, rd[13:12]}, 4'h1);
			cyc(4);
			check(lv_w, lvl(c, rd[13:12]));
			bus(1'b0, 8'h00, 32'h0, 4'hf);
			check(rd, c);
		end
		bus(1'b1, 8'h00, 32'hffffffff, 4'h4);
		bus(1'b0, 8'h00, 32'h0, 4'hf);
		check(rd, c | 32'h30000);
		bus(1'b1, 8'h00, 32'h11c, 4'hf);
		bus(1'b1, 8'h00, 32'h10, 4'hf);
		cyc(4);
		check({led_o[11], led_o[4], led_o[1]}, 3'h7);
		press(4);
		check(lat_w, 7'h07);
		fpic_operator_i.set_switch(1'b1);
		press(4);
		check(lat_w, 7'h08);
		bus(1'b1, 8'h00, 32'h20011, 4'hf);
		mode(17, 2'h2);
		press(3);
		check({silence_o, led_o[15]}, 2'h3);
		press(3);
		check({silence_o, led_o[15]}, 2'h0);
		press(2);
		check(buzzer_o, 1'b0);
		bus(1'b1, 8'h00, 32'h10, 4'hf);
		press(4);
		check(led_o[0], 1'b0);
		bus(1'b1, 8'h04, 32'h41, 4'hf);
		cyc(200);
		check({buzzer_o, led_o[16]}, 2'h3);
		cyc(2000);
		check(buzzer_o, 1'b0);
		cyc(9000);
		check(buzzer_o, 1'b1);
		press(4);
		bus(1'b0, 8'h04, 32'h0, 4'hf);
		check(rd[6:0], 7'h0);
		bus(1'b0, 8'h0c, 32'h0, 4'hf);
		check(rd[27], 1'b1);
		fpic_operator_i.set_key(0, 1'b1);
		cyc(10);
		fpic_operator_i.set_key(0, 1'b0);
		cyc(60);
		check(buzzer_o, 1'b1);
		cyc(300);
		check(buzzer_o, 1'b0);
		fpic_operator_i.set_key(0, 1'b1);
		cyc(2100);
		check(buzzer_o, 1'b1);
		cyc(200);
		check(buzzer_o, 1'b0);
		cyc(200);
		check(buzzer_o, 1'b1);
		cyc(200);
		fpic_operator_i.set_key(0, 1'b0);
		cyc(300);
		check(buzzer_o, 1'b0);
		for (i = 0; i < 4; i = i + 1) begin
			bus(1'b1, 8'h04, 32'h200 << (2 * i), 4'hf);
			mode(6 + i, 2'h1);
			bus(1'b1, 8'h04, 32'h300 << (2 * i), 4'hf);
			mode(6 + i, 2'h2);
		end
		bus(1'b1, 8'h04, 32'h0, 4'hf);
		press(7);
		check(led_o[9], 1'b1);
		press(7);
		check(led_o[9], 1'b0);
		bus(1'b0, 8'h10, 32'h0, 4'hf);
		check(rd, 32'h0000_009d);
		bus(1'b1, 8'h10, 32'h0000_01ff, 4'h3);
		bus(1'b0, 8'h10, 32'h0, 4'hf);
		check(rd, 32'h0);
		bus(1'b1, 8'h00, 32'h0, 4'hf);
		mode(2, 2'h1);
		for (i = 0; i < 6; i = i + 1) begin
			bus(1'b1, 8'h00, dly(i), 4'hf);
			mode(13, (i == 1) ? 2'h1 : (i > 2) ? 2'h0 : 2'h2);
			check(force_fire_o, i == 2);
		end
		results;
	end
endmodule // front_panel_indicator_control_test
bind fpic_top fpic_props fpic_props_i (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
	.wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
	.wb_dat_i(wb_dat_i), .wb_ack_o(wb_ack_o), .led_o(led_o), .reset_o(reset_o));
